/* File: core_cycle_timing_sequencer.sv */
`timescale 1ns/100ps
`include "cycle_timing_defs.svh"
module core_cycle_timing_sequencer
(
   input wire logic core_clk, // Core clock, 100 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic instr_start, // Decoder offers a new instruction.
   input wire cycle_timing_pkg::instr_class_t instr_class, // Its class.
   input wire logic irq_inserted, // Long call comes from interrupt.
   input wire logic [7:0] sfr_addr, // Register address.
   input wire logic sfr_wr, // Register write strobe.
   input wire logic [7:0] sfr_wdata, // Register write data.
   input wire logic [15:0] fetch_addr, // Code fetch address.
   input wire logic [7:0] code_rdata, // Internal program memory data.
   output logic [7:0] sfr_rdata, // Register read data.
   output logic [7:0] fetch_data, // Opcode byte to the decoder.
   output logic first_cycle, // First clock of an instruction.
   output logic instr_done, // Last clock of an instruction.
   output logic busy, // An instruction is executing.
   output logic timer_tick, // Timer advance enable.
   output logic ext_rd_n, // External data read strobe.
   output logic ext_wr_n, // External data write strobe.
   output logic code_fetch_n, // External program fetch strobe.
   output logic ale // Address-latch strobe.
);
   // -----------------------------------------------------------
   // State
   // -----------------------------------------------------------
   typedef struct packed {
      cycle_timing_pkg::seq_state_t st;
      logic [3:0] remain;
      logic first;
      logic done;
      logic xmove;
      logic xwrite;
      logic [7:0] wait_reg;
      logic [7:0] rdata;
      logic [7:0] fdata;
      logic rd_n;
      logic wr_n;
      logic tick;
      logic cfetch_n;
   } seq_t;

   seq_t s_q;
   seq_t s_d;
   logic accept;
   logic [3:0] base_len;
   logic [3:0] total_len;
   logic first_next;

   // -----------------------------------------------------------
   // Duration table
   // -----------------------------------------------------------
   // Base duration of each class; one machine cycle is one clock.
   always_comb
   begin
      unique case (instr_class)
         cycle_timing_pkg::cls_one: base_len = `CYC_ONE;
         cycle_timing_pkg::cls_two: base_len = `CYC_TWO;
         cycle_timing_pkg::cls_three: base_len = `CYC_THREE;
         cycle_timing_pkg::cls_code_read: base_len = `CYC_FOUR;
         cycle_timing_pkg::cls_xmove_rd: base_len = `CYC_FOUR;
         cycle_timing_pkg::cls_xmove_wr: base_len = `CYC_FOUR;
         cycle_timing_pkg::cls_branch3: base_len = `CYC_THREE;
         cycle_timing_pkg::cls_branch4: base_len = `CYC_FOUR;
         cycle_timing_pkg::cls_bit: base_len = `CYC_TWO;
         cycle_timing_pkg::cls_stack: base_len = `CYC_TWO;
         cycle_timing_pkg::cls_long_call: base_len = irq_inserted ? `CYC_IRQ_CALL : `CYC_FOUR;
         default: base_len = `CYC_ONE;
      endcase
   end

   // External moves are stretched by the low three wait bits only;
   // the upper bits are kept for readback but never counted.
   always_comb
   begin
      if (instr_class == cycle_timing_pkg::cls_xmove_rd || instr_class == cycle_timing_pkg::cls_xmove_wr)
         total_len = base_len + {1'b0, s_q.wait_reg[`WAIT_FIELD_MSB:`WAIT_FIELD_LSB]};
      else
         total_len = base_len;
   end

   // A new instruction is taken when idle or in the last clock of the
   // previous one, so back-to-back instructions lose no clock.
   assign accept = instr_start && (s_q.st == cycle_timing_pkg::st_idle || s_q.done);
   assign first_next = accept;

   // -----------------------------------------------------------
   // Next state
   // -----------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.first = 1'b0;
      s_d.done = 1'b0;
      s_d.tick = 1'b1;
      s_d.cfetch_n = 1'b1;
      s_d.rd_n = 1'b1;
      s_d.wr_n = 1'b1;
      if (accept)
      begin
         s_d.st = cycle_timing_pkg::st_run;
         s_d.remain = total_len - 4'h1;
         s_d.first = 1'b1;
         s_d.done = (total_len == 4'h1);
         s_d.xmove = (instr_class == cycle_timing_pkg::cls_xmove_rd) ||
            (instr_class == cycle_timing_pkg::cls_xmove_wr);
         s_d.xwrite = (instr_class == cycle_timing_pkg::cls_xmove_wr);
      end
      else if (s_q.st == cycle_timing_pkg::st_run)
      begin
         if (s_q.done)
         begin
            s_d.st = cycle_timing_pkg::st_idle;
            s_d.xmove = 1'b0;
            s_d.remain = 4'h0;
         end
         else
         begin
            s_d.remain = s_q.remain - 4'h1;
            s_d.done = (s_q.remain == 4'h1);
            // Strobe stands from the second clock to the last of a move.
            s_d.rd_n = !(s_q.xmove && !s_q.xwrite);
            s_d.wr_n = !(s_q.xmove && s_q.xwrite);
         end
      end
      // Register write; the whole byte is kept for readback.
      if (sfr_wr && sfr_addr == `WAIT_REG_ADDR)
         s_d.wait_reg = sfr_wdata;
      // Reads of other addresses return zero from this block.
      s_d.rdata = (sfr_addr == `WAIT_REG_ADDR) ? s_q.wait_reg : 8'h00;
      // Top of code space is filled with the no-operation opcode.
      if (fetch_addr >= `CODE_TOP_START)
         s_d.fdata = `NOP_OPCODE;
      else
         s_d.fdata = code_rdata;
   end

   // -----------------------------------------------------------
   // Registers
   // -----------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q.st <= cycle_timing_pkg::st_idle;
         s_q.remain <= 4'h0;
         s_q.first <= 1'b0;
         s_q.done <= 1'b0;
         s_q.xmove <= 1'b0;
         s_q.xwrite <= 1'b0;
         s_q.wait_reg <= `WAIT_REG_RESET;
         s_q.rdata <= 8'h00;
         s_q.fdata <= `NOP_OPCODE;
         s_q.rd_n <= 1'b1;
         s_q.wr_n <= 1'b1;
         s_q.tick <= 1'b0;
         s_q.cfetch_n <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // -----------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------
   assign sfr_rdata = s_q.rdata;
   assign fetch_data = s_q.fdata;
   assign first_cycle = s_q.first;
   assign instr_done = s_q.done;
   assign busy = (s_q.st == cycle_timing_pkg::st_run);
   assign timer_tick = s_q.tick;
   assign ext_rd_n = s_q.rd_n;
   assign ext_wr_n = s_q.wr_n;
   assign code_fetch_n = s_q.cfetch_n;

   // The strobe pulse needs a falling-edge flop, kept in its own module.
   ale_strobe_gen u_ale
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .first_next(first_next),
      .ale(ale)
   );

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   // Helper: clocks elapsed in the current instruction and its length.
   logic [3:0] chk_cnt_q;
   logic [3:0] chk_len_q;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         chk_cnt_q <= 4'h0;
         chk_len_q <= 4'h0;
      end
      else if (accept)
      begin
         chk_cnt_q <= 4'h1;
         chk_len_q <= total_len;
      end
      else if (busy && !s_q.done)
         chk_cnt_q <= chk_cnt_q + 4'h1;
   end

   property p_done_at_length;
      @(posedge core_clk) disable iff (!reset_n)
      instr_done |-> chk_cnt_q == chk_len_q;
   endproperty
   a_done_at_length: assert property (p_done_at_length)
      else $error("Instruction ended at the wrong clock.");

   property p_one_clock;
      @(posedge core_clk) disable iff (!reset_n)
      accept && instr_class == cycle_timing_pkg::cls_one |=> first_cycle && instr_done;
   endproperty
   a_one_clock: assert property (p_one_clock)
      else $error("One-clock instruction did not end at once.");

   property p_two_clock;
      @(posedge core_clk) disable iff (!reset_n)
      accept && (instr_class == cycle_timing_pkg::cls_two || instr_class == cycle_timing_pkg::cls_bit ||
         instr_class == cycle_timing_pkg::cls_stack) |=> !instr_done ##1 instr_done;
   endproperty
   a_two_clock: assert property (p_two_clock)
      else $error("Two-clock instruction has the wrong length.");

   property p_three_clock;
      @(posedge core_clk) disable iff (!reset_n)
      accept && (instr_class == cycle_timing_pkg::cls_three || instr_class == cycle_timing_pkg::cls_branch3)
      |=> !instr_done [*2] ##1 instr_done;
   endproperty
   a_three_clock: assert property (p_three_clock)
      else $error("Three-clock instruction has the wrong length.");

   property p_four_clock;
      @(posedge core_clk) disable iff (!reset_n)
      accept && (instr_class == cycle_timing_pkg::cls_code_read || instr_class == cycle_timing_pkg::cls_branch4 ||
         (instr_class == cycle_timing_pkg::cls_long_call && !irq_inserted)) |=> !instr_done [*3] ##1 instr_done;
   endproperty
   a_four_clock: assert property (p_four_clock)
      else $error("Four-clock instruction has the wrong length.");

   property p_irq_call;
      @(posedge core_clk) disable iff (!reset_n)
      accept && instr_class == cycle_timing_pkg::cls_long_call && irq_inserted
      |=> !instr_done [*2] ##1 instr_done;
   endproperty
   a_irq_call: assert property (p_irq_call)
      else $error("Inserted long call did not take three clocks.");

   property p_xmove_len;
      @(posedge core_clk) disable iff (!reset_n)
      accept && (instr_class == cycle_timing_pkg::cls_xmove_rd || instr_class == cycle_timing_pkg::cls_xmove_wr)
      |=> chk_len_q == `CYC_FOUR + {1'b0, $past(s_q.wait_reg[`WAIT_FIELD_MSB:`WAIT_FIELD_LSB])};
   endproperty
   a_xmove_len: assert property (p_xmove_len)
      else $error("External move not stretched by the wait count.");

   property p_wait_write;
      @(posedge core_clk) disable iff (!reset_n)
      sfr_wr && sfr_addr == `WAIT_REG_ADDR
      |=> ##1 sfr_rdata == $past(sfr_wdata, 2) || $past(sfr_addr) != `WAIT_REG_ADDR;
   endproperty
   a_wait_write: assert property (p_wait_write)
      else $error("Wait register readback does not match the write.");

   property p_tick;
      @(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> timer_tick;
   endproperty
   a_tick: assert property (p_tick)
      else $error("Timer tick missing on a core clock.");

   property p_no_code_fetch;
      @(posedge core_clk) disable iff (!reset_n)
      busy |-> code_fetch_n && s_q.first == (chk_cnt_q == 4'h1);
   endproperty
   a_no_code_fetch: assert property (p_no_code_fetch)
      else $error("External fetch strobe or first-clock flag wrong.");

   property p_top_nop;
      @(posedge core_clk) disable iff (!reset_n)
      fetch_addr >= `CODE_TOP_START |=> fetch_data == `NOP_OPCODE;
   endproperty
   a_top_nop: assert property (p_top_nop)
      else $error("Fetch from top of code space was not a no-operation.");
endmodule

/* File: cycle_timing_defs.svh */
`ifndef CYCLE_TIMING_DEFS_SVH
`define CYCLE_TIMING_DEFS_SVH
// -----------------------------------------------------------
// Register map and reset values
// -----------------------------------------------------------
`define WAIT_REG_ADDR 8'h9f
`define WAIT_REG_RESET 8'h00
`define WAIT_FIELD_MSB 2
`define WAIT_FIELD_LSB 0
// -----------------------------------------------------------
// Instruction durations in core clocks
// -----------------------------------------------------------
`define CYC_ONE 4'h1
`define CYC_TWO 4'h2
`define CYC_THREE 4'h3
`define CYC_FOUR 4'h4
`define CYC_IRQ_CALL 4'h3
// -----------------------------------------------------------
// Code space limits and filler opcode
// -----------------------------------------------------------
`define CODE_TOP_START 16'hf800
`define NOP_OPCODE 8'h00
`endif

/* File: cycle_timing_pkg.sv */
package cycle_timing_pkg;
   // Instruction timing classes as reported by the decoder.
   typedef enum logic [3:0] {
      cls_one,
      cls_two,
      cls_three,
      cls_code_read,
      cls_xmove_rd,
      cls_xmove_wr,
      cls_branch3,
      cls_branch4,
      cls_bit,
      cls_stack,
      cls_long_call
   } instr_class_t;
   // Sequencer states.
   typedef enum logic {
      st_idle,
      st_run
   } seq_state_t;
endpackage

/* File: ale_strobe_gen.sv */
`timescale 1ns/100ps
// The strobe must be high only for the first half of a clock,
// so a rising-edge and a falling-edge flop are combined.
module ale_strobe_gen
(
   input wire logic core_clk, // Core clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic first_next, // Next clock is an instruction's first.
   output logic ale // Address-latch strobe.
);
   typedef struct packed {
      logic rise;
   } ale_pos_t;
   ale_pos_t r_q;
   ale_pos_t r_d;
   logic fall_q;

   // Toggle on the rising edge that opens a first clock.
   always_comb
   begin
      r_d = r_q;
      r_d.rise = r_q.rise ^ first_next;
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   // Falling edge copies the toggle back, ending the pulse mid-clock.
   always_ff @(negedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         fall_q <= 1'b0;
      else
         fall_q <= r_q.rise;
   end

   assign ale = r_q.rise ^ fall_q;
endmodule

/* File: ext_ram_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// External data RAM seen through its read and write strobes
// ------------------------------------------------------------
module ext_ram_model
#(
   parameter int ACCESS_CLKS = 3
)
(
   input wire logic core_clk, // Core clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic ext_rd_n, // Read strobe, active low.
   input wire logic ext_wr_n, // Write strobe, active low.
   output logic too_slow // Sticky: a strobe ended before the RAM settled.
);
   int low_cnt = 0;
   logic too_slow_q = 1'b0;

   assign too_slow = too_slow_q;

   // Strobe width is measured in clocks; the flag survives reset so a
   // violation is never lost when a move is aborted.
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         low_cnt <= 0;
      else if (!ext_rd_n || !ext_wr_n)
         low_cnt <= low_cnt + 1;
      else
      begin
         if (low_cnt != 0 && low_cnt < ACCESS_CLKS)
            too_slow_q <= 1'b1;
         low_cnt <= 0;
      end
   end
endmodule

/* File: core_cycle_timing_sequencer_bench.sv */
`timescale 1ns/100ps
`define check(got, exp, msg) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("wrong value at %0t: %s", $time, msg); \
      end \
   end
module core_cycle_timing_sequencer_bench;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   typedef struct {
      cycle_timing_pkg::instr_class_t cls;
      logic irq;
      int n;
      logic rd;
      logic wr;
   } row_t;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic instr_start = 1'b0;
   cycle_timing_pkg::instr_class_t instr_class = cycle_timing_pkg::cls_one;
   logic irq_inserted = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [15:0] fetch_addr = 16'h0000;
   logic [7:0] code_rdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [7:0] fetch_data;
   logic first_cycle, instr_done, busy, timer_tick, ext_rd_n, ext_wr_n, code_fetch_n, ale;
   logic ram_too_slow;
   int n_errors = 0;
   int num_checks = 0;
   // Class, interrupt flag, clocks, read move, write move (wait count 0).
   row_t rows [12] = '{
      '{cycle_timing_pkg::cls_one, 1'b0, 1, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_two, 1'b0, 2, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_three, 1'b0, 3, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_code_read, 1'b0, 4, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_xmove_rd, 1'b0, 4, 1'b1, 1'b0},
      '{cycle_timing_pkg::cls_xmove_wr, 1'b0, 4, 1'b0, 1'b1},
      '{cycle_timing_pkg::cls_branch3, 1'b0, 3, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_branch4, 1'b0, 4, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_bit, 1'b0, 2, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_stack, 1'b0, 2, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_long_call, 1'b0, 4, 1'b0, 1'b0},
      '{cycle_timing_pkg::cls_long_call, 1'b1, 3, 1'b0, 1'b0}
   };

   always #5 core_clk = ~core_clk;

   // ------------------------------------------------------------
   // Design and far-side model
   // ------------------------------------------------------------
   core_cycle_timing_sequencer dut_u (.core_clk(core_clk), .reset_n(reset_n), .instr_start(instr_start),
      .instr_class(instr_class), .irq_inserted(irq_inserted), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .fetch_addr(fetch_addr), .code_rdata(code_rdata), .sfr_rdata(sfr_rdata),
      .fetch_data(fetch_data), .first_cycle(first_cycle), .instr_done(instr_done), .busy(busy),
      .timer_tick(timer_tick), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .code_fetch_n(code_fetch_n),
      .ale(ale));
   ext_ram_model #(.ACCESS_CLKS(3)) ram_u (.core_clk(core_clk), .reset_n(reset_n), .ext_rd_n(ext_rd_n),
      .ext_wr_n(ext_wr_n), .too_slow(ram_too_slow));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Runs one instruction and follows it clock by clock; the latch strobe is
   // looked at in both halves because its falling edge is mid-clock.
   task automatic run_instr(input cycle_timing_pkg::instr_class_t cls, input logic irq, input int n,
      input logic rd, input logic wr);
      @(negedge core_clk);
      instr_start = 1'b1;
      instr_class = cls;
      irq_inserted = irq;
      for (int k = 1; k <= n; k++)
      begin
         @(posedge core_clk);
         #2;
         `check(ale, (k == 1), "latch strobe in first half")
         @(negedge core_clk);
         instr_start = 1'b0;
         #1;
         `check(ale, 1'b0, "latch strobe in second half")
         `check(first_cycle, (k == 1), "first clock flag")
         `check(busy, 1'b1, "busy during instruction")
         `check(instr_done, (k == n), "instruction length")
         `check(ext_rd_n, !(rd && k >= 2), "read strobe")
         `check(ext_wr_n, !(wr && k >= 2), "write strobe")
         `check(timer_tick, 1'b1, "timer advance")
         `check(code_fetch_n, 1'b1, "external fetch strobe")
      end
      @(negedge core_clk);
      `check(busy, 1'b0, "idle after instruction")
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge core_clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      sfr_addr = a;
      @(posedge core_clk);
      @(posedge core_clk);
      #1;
      `check(sfr_rdata, exp, "register read")
   endtask

   task automatic fetch_chk(input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(negedge core_clk);
      fetch_addr = a;
      code_rdata = d;
      @(posedge core_clk);
      #1;
      `check(fetch_data, exp, "fetched opcode")
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge core_clk);
      #1;
      `check(sfr_rdata, 8'h00, "read data in reset")
      `check(ext_rd_n, 1'b1, "read strobe in reset")
      @(negedge core_clk);
      reset_n = 1'b1;
      foreach (rows[i])
         run_instr(rows[i].cls, rows[i].irq, rows[i].n, rows[i].rd, rows[i].wr);
      // Back-to-back one-clock instructions make the strobe run at the clock rate.
      // The start is then held into a three-clock instruction, where it must be ignored.
      @(negedge core_clk);
      instr_start = 1'b1;
      instr_class = cycle_timing_pkg::cls_one;
      for (int j = 0; j < 3; j++)
      begin
         @(posedge core_clk);
         #2;
         `check(ale, 1'b1, "strobe at each first clock")
         @(negedge core_clk);
         if (j == 1)
            instr_class = cycle_timing_pkg::cls_three;
         #1;
         `check(first_cycle, 1'b1, "back-to-back start")
         `check(instr_done, (j < 2), "back-to-back length")
      end
      @(posedge core_clk);
      #2;
      `check(ale, 1'b0, "no strobe for an ignored start")
      @(negedge core_clk);
      instr_start = 1'b0;
      #1;
      `check(first_cycle, 1'b0, "start ignored while busy")
      `check(instr_done, 1'b0, "three-clock instruction runs on")
      @(negedge core_clk);
      `check(instr_done, 1'b1, "three-clock instruction ends")
      @(negedge core_clk);
      `check(busy, 1'b0, "idle after ignored start")
      rd_reg(8'h9f, 8'h00);
      wr_reg(8'h9f, 8'hfd);
      rd_reg(8'h9f, 8'hfd);
      run_instr(cycle_timing_pkg::cls_xmove_rd, 1'b0, 9, 1'b1, 1'b0);
      wr_reg(8'h9f, 8'h07);
      run_instr(cycle_timing_pkg::cls_xmove_wr, 1'b0, 11, 1'b0, 1'b1);
      wr_reg(8'h9e, 8'h55);
      rd_reg(8'h9e, 8'h00);
      rd_reg(8'h9f, 8'h07);
      fetch_chk(16'hf7ff, 8'ha5, 8'ha5);
      fetch_chk(16'hf800, 8'h3c, 8'h00);
      fetch_chk(16'hffff, 8'h5a, 8'h00);
      `check(ram_too_slow, 1'b0, "external strobe long enough")
      // A reset in mid-move must drop the strobe and clear the wait count.
      @(negedge core_clk);
      instr_start = 1'b1;
      instr_class = cycle_timing_pkg::cls_xmove_rd;
      @(negedge core_clk);
      instr_start = 1'b0;
      @(negedge core_clk);
      reset_n = 1'b0;
      #1;
      `check(ext_rd_n, 1'b1, "read strobe after abort")
      `check(busy, 1'b0, "busy after abort")
      @(negedge core_clk);
      reset_n = 1'b1;
      rd_reg(8'h9f, 8'h00);
      run_instr(cycle_timing_pkg::cls_xmove_rd, 1'b0, 4, 1'b1, 1'b0);
      results();
   end

   // The whole run is well under a thousand clocks.
   initial
   begin
      #50000;
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      results();
   end
endmodule
